// ### design/csw_defines.vh
`ifndef CSW_DEFINES_VH
`define CSW_DEFINES_VH

// --------
// Clock and widths
// --------
`define CSW_MCLK_NS      50
`define CSW_CODE_W       12
`define CSW_CNT_W        20

// --------
// Register map: channel base = index * 0x20, register at + offset * 4
// --------
`define CSW_CH_STRIDE    8'h20
`define CSW_REG_CODE     3'h0
`define CSW_REG_UPPER    3'h1
`define CSW_REG_LOWER    3'h2
`define CSW_REG_SETUP    3'h3
`define CSW_REG_TRIG     3'h4
`define CSW_REG_STATUS   3'h5

// --------
// channel_function_setup fields and reset values
// --------
`define CSW_STEP_LSB     0
`define CSW_PER_LSB      3
`define CSW_WAVE_LSB     8
`define CSW_PHASE_LSB    12
`define CSW_SETUP_MASK   14'h377f
`define CSW_SETUP_RST    14'h0000
`define CSW_CODE_RST     12'h000
`define CSW_UPPER_RST    12'hfff
`define CSW_LOWER_RST    12'h000

// --------
// Trigger bits
// --------
`define CSW_TRIG_UP      0
`define CSW_TRIG_LOW     1
`define CSW_TRIG_WAVE    2
`define CSW_TRIG_STOP    3

// --------
// waveform_select encodings
// --------
`define CSW_WAVE_TRI     3'h0
`define CSW_WAVE_SAW     3'h1
`define CSW_WAVE_INV     3'h2
`define CSW_WAVE_SINE    3'h4

// --------
// Sine table
// --------
`define CSW_SINE_PTS     24
`define CSW_SINE_LAST    5'h17
`define CSW_PH0_IDX      5'h00
`define CSW_PH90_IDX     5'h06
`define CSW_PH120_IDX    5'h08
`define CSW_PH240_IDX    5'h10

// --------
// Step periods in ns, selectors 1..15
// --------
`define CSW_SP1_NS       4000
`define CSW_SP2_NS       8000
`define CSW_SP3_NS       12000
`define CSW_SP4_NS       18000
`define CSW_SP5_NS       27000
`define CSW_SP6_NS       40500
`define CSW_SP7_NS       60750
`define CSW_SP8_NS       91130
`define CSW_SP9_NS       136690
`define CSW_SP10_NS      239200
`define CSW_SP11_NS      418610
`define CSW_SP12_NS      732560
`define CSW_SP13_NS      1281980
`define CSW_SP14_NS      2563960
`define CSW_SP15_NS      5127920

`endif

// ### design/csw_sine_rom.v
`timescale 1ns/1ps
`include "csw_defines.vh"

module csw_sine_rom
(
    idx,
    val
);
    input  wire [4:0]  idx;
    output reg  [11:0] val;

    // Fixed points; host has no way to alter them
    always @*
    begin
        case (idx)
            5'h00: val = 12'h800;
            5'h01: val = 12'h9a8;
            5'h02: val = 12'hb33;
            5'h03: val = 12'hc87;
            5'h04: val = 12'hd8b;
            5'h05: val = 12'he2f;
            5'h06: val = 12'he66;
            5'h07: val = 12'he2f;
            5'h08: val = 12'hd8b;
            5'h09: val = 12'hc87;
            5'h0a: val = 12'hb33;
            5'h0b: val = 12'h9a8;
            5'h0c: val = 12'h800;
            5'h0d: val = 12'h658;
            5'h0e: val = 12'h4cd;
            5'h0f: val = 12'h379;
            5'h10: val = 12'h275;
            5'h11: val = 12'h1d1;
            5'h12: val = 12'h19a;
            5'h13: val = 12'h1d1;
            5'h14: val = 12'h275;
            5'h15: val = 12'h379;
            5'h16: val = 12'h4cd;
            5'h17: val = 12'h658;
            default: val = 12'h800;
        endcase
    end

endmodule // csw_sine_rom

// ### design/csw_top.v
// Summary of operation
// R1 - Writing a channel code drives the output to it at once, aborting sequences.
// R2 - Step period zero applies a commanded code change in a single update.
// R3 - Move-up or move-low command walks the code to the chosen limit.
// R4 - Stepping code updates once per programmed step period.
// R5 - Step size selector 0..7 gives 1,2,3,4,6,8,16,32 LSB, default 1.
// R6 - Period selector 0 is no stepping; 1..15 give 4 us to 5127.92 us.
// R7 - Each intermediate code holds a full period, staircase ends on the limit.
// R8 - Host must not change step, period or code during a stepped move.
// R9 - Full move lasts period times ceiling of span over step.
// R10 - Each channel runs its own continuous waveform independently.
// R11 - Triangle ramps between lower and upper limit by step each period.
// R12 - Selector 000 is triangle; cycle is two times period times span steps.
// R13 - Selector 001 is rising sawtooth, 010 falling, both across the limits.
// R14 - Sawtooth cycle lasts period times ceiling of span over step plus one.
// R15 - Sine outputs 24 fixed points per cycle, one per step period.
// R16 - Selector 100 is sine, with codes the host cannot change.
// R17 - Sine table is 12-bit, 0x800 at 0, 0xe66 at 6, 0x19a at 18.
// R18 - Phase selector starts sine at index 0, 6, 8 or 16.
// R19 - Sawtooth jumps back to its starting limit and repeats until stopped.
`timescale 1ns/1ps
`include "csw_defines.vh"

module csw_top
#(
    parameter NCH       = 3,
    parameter SP1_CYC   = (`CSW_SP1_NS  + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP2_CYC   = (`CSW_SP2_NS  + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP3_CYC   = (`CSW_SP3_NS  + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP4_CYC   = (`CSW_SP4_NS  + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP5_CYC   = (`CSW_SP5_NS  + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP6_CYC   = (`CSW_SP6_NS  + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP7_CYC   = (`CSW_SP7_NS  + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP8_CYC   = (`CSW_SP8_NS  + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP9_CYC   = (`CSW_SP9_NS  + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP10_CYC  = (`CSW_SP10_NS + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP11_CYC  = (`CSW_SP11_NS + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP12_CYC  = (`CSW_SP12_NS + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP13_CYC  = (`CSW_SP13_NS + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP14_CYC  = (`CSW_SP14_NS + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS,
    parameter SP15_CYC  = (`CSW_SP15_NS + `CSW_MCLK_NS - 1) / `CSW_MCLK_NS
)
(
    input  wire                 mclk,
    input  wire                 rst,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [7:0]           paddr,
    input  wire [31:0]          pwdata,
    output wire                 pready,
    output wire [31:0]          prdata,
    output wire                 pslverr,
    output wire [NCH*12-1:0]    ch_code,
    output wire [NCH-1:0]       ch_busy
);

    // --------
    // Local constants
    // --------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_SLEW = 2'h1;
    localparam [1:0] ST_WAVE = 2'h2;
    localparam [2:0] LAST_CH = NCH - 1;

    // --------
    // Functions
    // --------
    function [12:0] step_lsb;
        input [2:0] sel;
        begin
            case (sel)                                           // R5
                3'h0: step_lsb = 13'h0001;
                3'h1: step_lsb = 13'h0002;
                3'h2: step_lsb = 13'h0003;
                3'h3: step_lsb = 13'h0004;
                3'h4: step_lsb = 13'h0006;
                3'h5: step_lsb = 13'h0008;
                3'h6: step_lsb = 13'h0010;
                3'h7: step_lsb = 13'h0020;
                default: step_lsb = 13'h0001;
            endcase
        end
    endfunction

    function [19:0] period_cyc;
        input [3:0] sel;
        begin
            case (sel)                                           // R6
                4'h1: period_cyc = SP1_CYC[19:0];
                4'h2: period_cyc = SP2_CYC[19:0];
                4'h3: period_cyc = SP3_CYC[19:0];
                4'h4: period_cyc = SP4_CYC[19:0];
                4'h5: period_cyc = SP5_CYC[19:0];
                4'h6: period_cyc = SP6_CYC[19:0];
                4'h7: period_cyc = SP7_CYC[19:0];
                4'h8: period_cyc = SP8_CYC[19:0];
                4'h9: period_cyc = SP9_CYC[19:0];
                4'ha: period_cyc = SP10_CYC[19:0];
                4'hb: period_cyc = SP11_CYC[19:0];
                4'hc: period_cyc = SP12_CYC[19:0];
                4'hd: period_cyc = SP13_CYC[19:0];
                4'he: period_cyc = SP14_CYC[19:0];
                4'hf: period_cyc = SP15_CYC[19:0];
                default: period_cyc = 20'h00000;
            endcase
        end
    endfunction

    // One step from cur toward tgt, clamped so it never passes tgt
    function [11:0] step_to;
        input [11:0] cur;
        input [11:0] tgt;
        input [12:0] stp;
        reg   [12:0] up;
        begin
            up = {1'b0, cur} + stp;
            if (cur < tgt)
                step_to = (up >= {1'b0, tgt}) ? tgt : up[11:0];
            else if ({1'b0, cur} <= {1'b0, tgt} + stp)
                step_to = tgt;
            else
                step_to = cur - stp[11:0];
        end
    endfunction

    function [4:0] phase_idx;
        input [1:0] sel;
        begin
            case (sel)                                           // R18
                2'h0: phase_idx = `CSW_PH0_IDX;
                2'h1: phase_idx = `CSW_PH90_IDX;
                2'h2: phase_idx = `CSW_PH120_IDX;
                default: phase_idx = `CSW_PH240_IDX;
            endcase
        end
    endfunction

    // --------
    // APB slave
    // --------
    // Zero wait states; read data is caught in the setup cycle
    reg  [31:0]         prdata_ff;
    reg                 pslverr_ff;
    wire [2:0]          ch_idx   = paddr[7:5];
    wire [2:0]          reg_idx  = paddr[4:2];
    wire                mapped   = (ch_idx <= LAST_CH) && (reg_idx <= `CSW_REG_STATUS);
    wire                setup_ph = psel && !penable;
    wire                wr_en    = psel && penable && pwrite && mapped;
    wire [NCH*32-1:0]   ch_rd;

    assign pready  = 1'b1;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end
        else if (setup_ph)
        begin
            prdata_ff  <= (mapped && !pwrite) ? ch_rd[ch_idx*32 +: 32] : 32'h00000000;
            pslverr_ff <= !mapped;
        end
    end

    // --------
    // Channel sequencers
    // --------
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1)
        begin : chan
            localparam [2:0] CH = g;
            reg  [11:0] code_ff;
            reg  [11:0] upper_ff;
            reg  [11:0] lower_ff;
            reg  [11:0] out_ff;
            reg  [11:0] tgt_ff;
            reg  [13:0] setup_ff;
            reg  [1:0]  st_ff;
            reg         dir_ff;
            reg  [4:0]  sidx_ff;
            reg  [19:0] cnt_ff;
            reg  [31:0] rd;
            wire        sel_wr   = wr_en && (ch_idx == CH);
            wire [12:0] stp      = step_lsb(setup_ff[`CSW_STEP_LSB +: 3]);
            wire [19:0] pcyc     = period_cyc(setup_ff[`CSW_PER_LSB +: 4]);
            wire [2:0]  wave     = setup_ff[`CSW_WAVE_LSB +: 3];
            wire [4:0]  ph_start = phase_idx(setup_ff[`CSW_PHASE_LSB +: 2]);
            wire        wr_code  = sel_wr && (reg_idx == `CSW_REG_CODE);
            wire        wr_trig  = sel_wr && (reg_idx == `CSW_REG_TRIG);
            wire        t_up     = wr_trig && pwdata[`CSW_TRIG_UP];
            wire        t_low    = wr_trig && pwdata[`CSW_TRIG_LOW];
            wire        t_wave   = wr_trig && pwdata[`CSW_TRIG_WAVE];
            wire        t_stop   = wr_trig && pwdata[`CSW_TRIG_STOP];
            wire        no_slew  = (pcyc == 20'h00000);
            // Tick after a full period of holding the current code
            wire        tick     = (st_ff != ST_IDLE) && !no_slew
                                   && (cnt_ff == pcyc - 20'h00001);  // R4 R7
            wire [11:0] sine_val;
            wire [11:0] nx_hi    = step_to(out_ff, upper_ff, stp);
            wire [11:0] nx_lo    = step_to(out_ff, lower_ff, stp);
            wire [11:0] nx_tgt   = step_to(out_ff, tgt_ff, stp);
            wire [11:0] lim      = t_up ? upper_ff : lower_ff;
            wire [4:0]  sidx_inc = (sidx_ff == `CSW_SINE_LAST) ? 5'h00
                                   : sidx_ff + 5'h01;

            csw_sine_rom u_rom
            (
                .idx (sidx_ff),
                .val (sine_val)                                  // R16 R17
            );

            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    code_ff  <= `CSW_CODE_RST;
                    upper_ff <= `CSW_UPPER_RST;
                    lower_ff <= `CSW_LOWER_RST;
                    setup_ff <= `CSW_SETUP_RST;
                end
                else if (sel_wr)
                begin
                    case (reg_idx)
                        `CSW_REG_CODE:  code_ff  <= pwdata[11:0];
                        `CSW_REG_UPPER: upper_ff <= pwdata[11:0];
                        `CSW_REG_LOWER: lower_ff <= pwdata[11:0];
                        `CSW_REG_SETUP: setup_ff <= pwdata[13:0] & `CSW_SETUP_MASK;
                        default:        code_ff  <= code_ff;
                    endcase
                end
            end

            // Period counter restarts on every command so the first step
            // also waits a whole period
            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                    cnt_ff <= 20'h00000;
                else if (wr_code || wr_trig || tick || st_ff == ST_IDLE)
                    cnt_ff <= 20'h00000;
                else
                    cnt_ff <= cnt_ff + 20'h00001;
            end

            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    out_ff  <= `CSW_CODE_RST;
                    tgt_ff  <= `CSW_CODE_RST;
                    st_ff   <= ST_IDLE;
                    dir_ff  <= 1'b1;
                    sidx_ff <= `CSW_PH0_IDX;
                end
                else if (wr_code)
                begin
                    out_ff <= pwdata[11:0];                      // R1
                    st_ff  <= ST_IDLE;
                end
                else if (t_stop)
                    st_ff <= ST_IDLE;
                else if (t_up || t_low)
                begin
                    tgt_ff <= lim;
                    if (no_slew)
                    begin
                        out_ff <= lim;                           // R2
                        st_ff  <= ST_IDLE;
                    end
                    else
                        st_ff <= ST_SLEW;                        // R3
                end
                else if (t_wave)
                begin
                    st_ff   <= ST_WAVE;                          // R10
                    dir_ff  <= 1'b1;
                    sidx_ff <= ph_start;                         // R18
                    case (wave)
                        `CSW_WAVE_INV:  out_ff <= upper_ff;
                        `CSW_WAVE_SINE: out_ff <= 12'h000;
                        default:        out_ff <= lower_ff;
                    endcase
                end
                else if (tick)
                begin
                    case (st_ff)
                        ST_SLEW:
                        begin
                            out_ff <= nx_tgt;                    // R7 R9
                            if (nx_tgt == tgt_ff)
                                st_ff <= ST_IDLE;
                        end
                        ST_WAVE:
                        begin
                            case (wave)
                                `CSW_WAVE_TRI:                   // R11 R12
                                begin
                                    out_ff <= dir_ff ? nx_hi : nx_lo;
                                    if (dir_ff && nx_hi == upper_ff)
                                        dir_ff <= 1'b0;
                                    else if (!dir_ff && nx_lo == lower_ff)
                                        dir_ff <= 1'b1;
                                end
                                `CSW_WAVE_SAW:                   // R13 R14 R19
                                    out_ff <= (out_ff >= upper_ff) ? lower_ff : nx_hi;
                                `CSW_WAVE_INV:                   // R13 R14 R19
                                    out_ff <= (out_ff <= lower_ff) ? upper_ff : nx_lo;
                                `CSW_WAVE_SINE:
                                    sidx_ff <= sidx_inc;         // R15
                                default:
                                    st_ff <= ST_IDLE;
                            endcase
                        end
                        default: st_ff <= ST_IDLE;
                    endcase
                end
            end

            always @*
            begin
                case (reg_idx)
                    `CSW_REG_CODE:   rd = {20'h00000, code_ff};
                    `CSW_REG_UPPER:  rd = {20'h00000, upper_ff};
                    `CSW_REG_LOWER:  rd = {20'h00000, lower_ff};
                    `CSW_REG_SETUP:  rd = {18'h00000, setup_ff};
                    `CSW_REG_STATUS: rd = {10'h000, st_ff, 3'h0, sidx_ff,
                                           ch_code[g*12 +: 12]};
                    default:         rd = 32'h00000000;
                endcase
            end

            // Sine points bypass out_ff so the index register drives the code
            assign ch_code[g*12 +: 12] = (st_ff == ST_WAVE && wave == `CSW_WAVE_SINE)
                                         ? sine_val : out_ff;
            assign ch_busy[g]          = (st_ff != ST_IDLE);
            assign ch_rd[g*32 +: 32]   = rd;
        end
    endgenerate

endmodule // csw_top

// ### test/csw_checker_assertions.sv
`timescale 1ns/1ps
`include "csw_defines.vh"
module csw_checker
#(
    parameter NCH     = 3,
    parameter SP1_CYC = 80
)
(
    input wire              mclk,
    input wire              rst,
    input wire              psel,
    input wire              penable,
    input wire              pwrite,
    input wire [7:0]        paddr,
    input wire [31:0]       pwdata,
    input wire              pready,
    input wire [31:0]       prdata,
    input wire              pslverr,
    input wire [NCH*12-1:0] ch_code,
    input wire [NCH-1:0]    ch_busy
);
// --------
// Shadow of channel 0 settings, tracked from the bus
// --------
reg  [11:0] prev_ff, up_ff, lo_ff, tgt_ff, wd_ff;
reg  [3:0]  per_ff;
reg  [2:0]  stp_ff;
reg         sl_ff;
reg  [19:0] cnt_ff;
wire        acc = psel && penable;
wire        wr  = acc && pwrite && paddr[7:5] == 3'h0;
wire [2:0]  ri  = paddr[4:2];
wire [11:0] cd  = ch_code[11:0];
wire        chg = cd != prev_ff;
wire        bad = paddr[7:5] >= NCH || ri > 3'h5;
wire [11:0] dif = cd > prev_ff ? cd - prev_ff : prev_ff - cd;
wire [11:0] sz  = stp_ff < 3'h4 ? stp_ff + 12'h1 : stp_ff == 3'h4 ? 12'h6 :
                  stp_ff == 3'h5 ? 12'h8 : stp_ff == 3'h6 ? 12'h10 : 12'h20;
always @(posedge mclk or posedge rst)
begin
    if (rst)
    begin
        prev_ff <= 12'h000; up_ff <= 12'hfff; lo_ff <= 12'h000; tgt_ff <= 12'h000;
        wd_ff <= 12'h000; per_ff <= 4'h0; stp_ff <= 3'h0; sl_ff <= 1'b0; cnt_ff <= 20'h0;
    end
    else
    begin
        prev_ff <= cd;
        cnt_ff  <= chg ? 20'h0 : cnt_ff + 20'h1;
        if (wr && ri == `CSW_REG_UPPER) up_ff <= pwdata[11:0];
        if (wr && ri == `CSW_REG_LOWER) lo_ff <= pwdata[11:0];
        if (wr && ri == `CSW_REG_SETUP) {per_ff, stp_ff} <= pwdata[6:0];
        if (wr && ri == `CSW_REG_CODE) {sl_ff, wd_ff} <= {1'b0, pwdata[11:0]};
        if (wr && ri == `CSW_REG_TRIG)
        begin
            sl_ff  <= (pwdata[0] || pwdata[1]) && !pwdata[3];
            tgt_ff <= pwdata[0] ? up_ff : lo_ff;
        end
    end
end
default clocking cb @(posedge mclk); endclocking
default disable iff (rst);
ready_high_a: assert property (pready) else $error("pready low");
bad_addr_err_a: assert property (acc && bad |-> pslverr) else $error("no error on bad address");
good_addr_ok_a: assert property (acc && !bad |-> !pslverr) else $error("error on good address");
bad_read_zero_a: assert property (acc && bad && !pwrite |-> prdata == 32'h0)
    else $error("bad address read not zero");
code_write_a: assert property (wr && ri == `CSW_REG_CODE |-> ##[1:2] cd == wd_ff && !ch_busy[0])
    else $error("code write not applied");
noslew_jump_a: assert property (wr && ri == `CSW_REG_TRIG && pwdata[0] && !pwdata[3] &&
    per_ff == 4'h0 |-> ##[1:2] cd == up_ff) else $error("no-slew move not immediate");
step_size_a: assert property (chg && sl_ff && per_ff != 4'h0 |->
    dif == sz || (cd == tgt_ff && dif <= sz)) else $error("wrong step size");
step_hold_a: assert property (chg && sl_ff && per_ff == 4'h1 |-> cnt_ff >= SP1_CYC - 1)
    else $error("step held too short");
move_end_a: assert property (sl_ff && ch_busy[0] && !wr ##1 !ch_busy[0] |-> cd == tgt_ff)
    else $error("move ended off target");
cover property (chg && sl_ff);
cover property (acc && bad);
cover property (chg && !sl_ff && ch_busy[0]);
endmodule // csw_checker
bind csw_top csw_checker #(.NCH(NCH), .SP1_CYC(SP1_CYC)) u_csw_checker (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .ch_code(ch_code), .ch_busy(ch_busy));

// ### test/csw_host_model.sv
`timescale 1ns/1ps
module csw_host_model
(
    input  wire        mclk,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [7:0]  paddr,
    output reg  [31:0] pwdata,
    input  wire        pready,
    input  wire [31:0] prdata,
    input  wire        pslverr
);
// --------
// APB master: one idle cycle after each transfer keeps drives apart
// --------
initial
begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
end
task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
begin
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
end
endtask
endmodule // csw_host_model

// ### test/csw_top_tb_top.sv
`timescale 1ns/1ps
`include "csw_defines.vh"
module csw_top_tb_top;
localparam P1 = 4, P2 = 6;
localparam [31:0] TU = 32'h1 << `CSW_TRIG_UP, TL = 32'h1 << `CSW_TRIG_LOW;
localparam [31:0] TW = 32'h1 << `CSW_TRIG_WAVE, TS = 32'h1 << `CSW_TRIG_STOP;
reg          mclk, rst;
wire         psel, penable, pwrite, pready, pslverr;
wire [7:0]   paddr;
wire [31:0]  pwdata, prdata;
wire [35:0]  ch_code;
wire [2:0]   ch_busy;
int          error_cnt = 0, samples_checked = 0, t[0:24], n;
logic [11:0] v[0:24];
logic [31:0] q;
logic        e;
logic [11:0] sine[0:23] = '{12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b, 12'he2f, 12'he66,
    12'he2f, 12'hd8b, 12'hc87, 12'hb33, 12'h9a8, 12'h800, 12'h658, 12'h4cd, 12'h379,
    12'h275, 12'h1d1, 12'h19a, 12'h1d1, 12'h275, 12'h379, 12'h4cd, 12'h658};
int          sz[8] = '{1, 2, 3, 4, 6, 8, 16, 32}, ix[4] = '{0, 6, 8, 16};
logic [2:0]  wm[3] = '{`CSW_WAVE_TRI, `CSW_WAVE_SAW, `CSW_WAVE_INV};
csw_top #(.SP1_CYC(P1), .SP2_CYC(P2)) u_csw_top (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ch_code(ch_code), .ch_busy(ch_busy));
csw_host_model u_csw_host_model (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
// --------
// Helpers
// --------
function [7:0] a(input [2:0] c, input [2:0] r); a = {c, r, 2'b00}; endfunction
function [31:0] su(input [2:0] s, input [3:0] p, input [2:0] w, input [1:0] ph);
    su = {18'h0, ph, 1'b0, w, 1'b0, p, s};
endfunction
task wr(input [7:0] ad, input [31:0] d); u_csw_host_model.xfer(1'b1, ad, d, q, e); endtask
task chk(input string nm, input logic [19:0] ex, input logic [19:0] got);
    samples_checked++;
    if (got !== ex)
    begin
        error_cnt++;
        $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
endtask
task rchk(input string nm, input [7:0] ad, input [19:0] exd, input exe);
    u_csw_host_model.xfer(1'b0, ad, 32'h0, q, e);
    chk(nm, exd, q[19:0]);
    chk(nm, exe, e);
endtask
// Records the code now and after each of the next n changes, with cycle stamps
task cap(input int n);
    int c, k;
    begin
        #1 k = 0; c = 0; v[0] = ch_code[11:0]; t[0] = 0;
        while (k < n && c < 5000)
        begin
            @(posedge mclk); #1; c++;
            if (ch_code[11:0] !== v[k]) begin k++; v[k] = ch_code[11:0]; t[k] = c; end
        end
    end
endtask
task wbusy;
    n = 0;
    do begin @(posedge mclk); #1; n++; end while (ch_busy[0] !== 1'b0 && n < 20000);
endtask
// --------
// Scenarios
// --------
task t_reset;
    rchk("code reset", a(0, `CSW_REG_CODE), 20'h0, 1'b0);
    rchk("upper reset", a(0, `CSW_REG_UPPER), 20'hfff, 1'b0);
    rchk("lower reset", a(0, `CSW_REG_LOWER), 20'h0, 1'b0);
    rchk("setup reset", a(0, `CSW_REG_SETUP), 20'h0, 1'b0);
    rchk("bad channel", a(3, `CSW_REG_CODE), 20'h0, 1'b1);
    rchk("bad register", a(0, 3'h6), 20'h0, 1'b1);
    $display("reset test done");
endtask
task t_noslew;
    wr(a(0, `CSW_REG_UPPER), 32'habc);
    wr(a(0, `CSW_REG_TRIG), TU);
    repeat (2) @(posedge mclk);
    #1 chk("noslew code", 12'habc, ch_code[11:0]);
    $display("no-slew test done");
endtask
task t_slew;
    wr(a(0, `CSW_REG_UPPER), 32'h64);
    for (int i = 0; i < 8; i++)
    begin
        wr(a(0, `CSW_REG_SETUP), su(i, (i % 2) + 1, `CSW_WAVE_TRI, 0));
        wr(a(0, `CSW_REG_CODE), 32'h0);
        wr(a(0, `CSW_REG_TRIG), TU);
        wbusy;
        chk("slew time", ((i % 2) ? P2 : P1) * ((100 + sz[i] - 1) / sz[i]), n);
        chk("slew end", 12'h064, ch_code[11:0]);
    end
    wr(a(0, `CSW_REG_TRIG), TL);
    wbusy;
    chk("low time", P2 * 4, n);
    chk("low end", 12'h000, ch_code[11:0]);
    $display("slew test done");
endtask
task t_abort;
    wr(a(0, `CSW_REG_SETUP), su(0, 1, `CSW_WAVE_TRI, 0));
    wr(a(0, `CSW_REG_TRIG), TW);
    repeat (6) @(posedge mclk);
    wr(a(0, `CSW_REG_CODE), 32'h123);
    repeat (2) @(posedge mclk);
    #1 chk("abort code", 12'h123, ch_code[11:0]);
    chk("abort busy", 1'b0, ch_busy[0]);
    repeat (3 * P1) @(posedge mclk);
    #1 chk("abort hold", 12'h123, ch_code[11:0]);
    $display("abort test done");
endtask
task t_wave;
    wr(a(0, `CSW_REG_LOWER), 32'h10);
    wr(a(0, `CSW_REG_UPPER), 32'h18);
    for (int m = 0; m < 3; m++)
    begin
        wr(a(0, `CSW_REG_SETUP), su(1, 1, wm[m], 0));
        wr(a(0, `CSW_REG_CODE), m == 2 ? 32'h18 : 32'h10);
        wr(a(0, `CSW_REG_TRIG), TW);
        cap(8);
        for (int k = 0; k < 9; k++)
            chk("wave code", m == 0 ? 16 + 2 * (k <= 4 ? k : 8 - k) :
                m == 1 ? 16 + 2 * (k % 5) : 24 - 2 * (k % 5), v[k]);
        chk("wave cycle", (m == 0 ? 8 : 5) * P1, t[m == 0 ? 8 : 5]);
        wr(a(0, `CSW_REG_TRIG), TS);
    end
    wr(a(0, `CSW_REG_SETUP), su(1, 1, 3'h3, 0));
    wr(a(0, `CSW_REG_TRIG), TW);
    wbusy;
    chk("bad wave stop", P1, n);
    $display("waveform test done");
endtask
task t_sine;
    wr(a(1, `CSW_REG_SETUP), su(0, 1, `CSW_WAVE_TRI, 0));
    wr(a(1, `CSW_REG_TRIG), TW);
    for (int p = 0; p < 4; p++)
    begin
        wr(a(0, `CSW_REG_SETUP), su(0, 1, `CSW_WAVE_SINE, p));
        wr(a(0, `CSW_REG_CODE), sine[ix[p]]);
        wr(a(0, `CSW_REG_TRIG), TW);
        cap(p == 0 ? 24 : 2);
        for (int k = 0; k <= (p == 0 ? 24 : 2); k++)
            chk("sine code", sine[(ix[p] + k) % 24], v[k]);
        if (p == 0) chk("sine cycle", 24 * P1, t[24]);
        wr(a(0, `CSW_REG_TRIG), TS);
    end
    chk("other channel busy", 1'b1, ch_busy[1]);
    $display("sine test done");
endtask
task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
initial
begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
end
initial
begin
    #3000000;
    error_cnt++;
    complete_run;
end
initial
begin
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_noslew;
    t_slew;
    t_abort;
    t_wave;
    t_sine;
    complete_run;
end
endmodule // csw_top_tb_top
